// ### rtl/dsc_core.sv
// Opcode execution core with status, auxiliary and product state behind Wishbone
//
// Design decisions made here: the address map and the Wishbone register port.
`include "dsc_defs.svh"

// Summary of operation
// - Page zero holds only block two and the mapped registers; blocks 0/1 sit on pages 4-7.
// - Sign extend and product shift mode are not reset; software sets them.
// - Status word zero packs select, wrap, saturate, a one, mask and the page.
// - Direct status stores go to page zero as if the page were zero.
// - Storing the selected aux register while modifying it stores the old value.
// - Branches and calls, not the accumulator ones, modify aux registers.
// - Accumulator low store shifts left by zero, one or four.
// - The most negative square gives the correct positive product.
// - Multiplies do not hold off interrupt acceptance.
// - Port opcodes carry a four-bit port address.
// - Table writes raise the program strobe, port writes the port strobe.
// - Conditional subtract takes one cycle, repeats and leaves the accumulator ready.
// - Aux register updates and nonzero tests are full 16-bit.
module dsc_core (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 wb_cyc,
    input  wire logic                 wb_stb,
    input  wire logic                 wb_we,
    input  wire logic [7:0]           wb_adr,
    input  wire logic [3:0]           wb_sel,
    input  wire logic [31:0]          wb_dat_w,
    output      logic [31:0]          wb_dat_r,
    output      logic                 wb_ack,
    output      dsc_pkg::dsc_mem_s    mem,
    output      dsc_pkg::dsc_region_e mem_region,
    output      logic                 irq_window
);
    // ************************************************
    // State and decode
    // ************************************************
    logic [15:0]          ar [8];
    logic [15:0]          st0, insn, opnd, treg, pc, ret_pc;
    logic [31:0]          acc, prod, rd, sub_op, sub_res;
    logic [32:0]          sub_diff;
    logic                 sign_extend_enable, blk0_prog;
    logic [1:0]           pm;
    logic [7:0]           rpt_cnt, rpt_pend;
    dsc_pkg::dsc_state_e  state;
    dsc_pkg::dsc_opc_e    cls;
    dsc_pkg::dsc_mem_s    next_mem;
    logic [3:0]           arg;
    logic [2:0]           asel, mod, sh;
    logic [5:0]           ix;
    logic                 ind, exec, go, wr, busy, mod_en, mem_op, is_rep;
    logic [15:0]          cur_ar, st0_rd, st1_rd, dir_addr;

    assign cls      = dsc_pkg::dsc_opc_e'(insn[`DSC_OP_CLS]);
    assign arg      = insn[`DSC_OP_ARG];
    assign ind      = insn[`DSC_OP_IND];
    assign mod      = insn[`DSC_OP_MOD];
    assign asel     = st0[`DSC_ST_ASEL];
    assign cur_ar   = ar[asel];
    assign exec     = (state == dsc_pkg::DSC_EXEC);
    assign busy     = (state != dsc_pkg::DSC_IDLE);
    assign st0_rd   = st0 | (16'h1 << `DSC_ST_ONE);
    assign st1_rd   = {12'h0, blk0_prog, pm, sign_extend_enable};
    assign dir_addr = {st0[`DSC_ST_PAGE], insn[`DSC_OP_OFF]};
    assign is_rep   = (cls == dsc_pkg::OPC_MISC) && (arg == `DSC_MISC_REP
                      || arg == `DSC_MISC_REPK);
    // Of the branches and calls, only the accumulator ones skip the modify field in the low bits
    assign mem_op   = (cls == dsc_pkg::OPC_STS0) || (cls == dsc_pkg::OPC_STS1)
                      || (cls == dsc_pkg::OPC_STAR) || (cls == dsc_pkg::OPC_STACC)
                      || (cls == dsc_pkg::OPC_MUL) || (cls == dsc_pkg::OPC_CSUB)
                      || (cls == dsc_pkg::OPC_MISC && arg == `DSC_MISC_REP);
    assign mod_en   = (mem_op && ind) || (cls == dsc_pkg::OPC_BR)
                      || (cls == dsc_pkg::OPC_CALL)
                      || (cls == dsc_pkg::OPC_MISC && arg == `DSC_MISC_BNZ);
    // Codes other than one and four store unshifted
    assign sh       = (arg == 4'h1) ? 3'h1 : (arg == 4'h4) ? 3'h4 : 3'h0;

    // Step of an aux register, wrapping at 16 bits
    function automatic logic [15:0] ar_step(input logic [15:0] v, input logic [2:0] m,
                                            input logic [15:0] x);
        case (m)
            3'h1:    ar_step = v + 16'h1;
            3'h2:    ar_step = v - 16'h1;
            3'h3:    ar_step = v + x;
            3'h4:    ar_step = v - x;
            default: ar_step = v;
        endcase
    endfunction

    // Data page map; block zero leaves data space when it serves program
    function automatic dsc_pkg::dsc_region_e region(input logic [15:0] a, input logic c);
        if (a[15:7] == 9'h0)
            region = (a[6:5] == `DSC_BLK2_SEL) ? dsc_pkg::RG_BLK2 :
                     (a[6:0] <= `DSC_MMR_TOP) ? dsc_pkg::RG_MMR : dsc_pkg::RG_NONE;
        else if (a[15:8] == `DSC_BLK0_PAGE)
            region = c ? dsc_pkg::RG_NONE : dsc_pkg::RG_BLK0;
        else if (a[15:8] == `DSC_BLK1_PAGE)
            region = dsc_pkg::RG_BLK1;
        else if (a[15:9] == 7'h0)
            region = dsc_pkg::RG_NONE;
        else
            region = dsc_pkg::RG_EXT;
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] m16(input logic [15:0] o, input logic [15:0] n,
                                        input logic [1:0] s);
        m16 = {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
    endfunction

    // ************************************************
    // Wishbone slave
    // ************************************************
    // Every access stalls while an opcode runs, so software never races the core
    assign ix = wb_adr[7:2];
    assign go = wb_cyc && wb_stb && !wb_ack && !busy;
    assign wr = go && wb_we;

    // Read mux; unmapped words read zero
    always_comb
    begin
        rd = 32'h0;
        if (ix[5:3] == `DSC_IX_AR)
            rd = {16'h0, ar[ix[2:0]]};
        else
            case (ix)
                `DSC_IX_INSN: rd = {16'h0, insn};
                `DSC_IX_OPND: rd = {16'h0, opnd};
                `DSC_IX_ST0:  rd = {16'h0, st0_rd};
                `DSC_IX_MODE: rd = {16'h0, st1_rd};
                `DSC_IX_ACC:  rd = acc;
                `DSC_IX_PROD: rd = prod;
                `DSC_IX_TREG: rd = {16'h0, treg};
                `DSC_IX_CORE: rd = {ret_pc, rpt_cnt, pc[7:0]};
                default:      rd = 32'h0;
            endcase
    end

    // Ack one cycle after the request, with read data registered beside it
    always_ff @(posedge sys_clk or posedge reset)
        if (reset)
        begin
            wb_ack   <= 1'b0;
            wb_dat_r <= 32'h0;
        end
        else
        begin
            wb_ack   <= go;
            wb_dat_r <= (go && !wb_we) ? rd : 32'h0;
        end

    // ************************************************
    // Software registers
    // ************************************************
    // Opcode, operand, multiplicand and block configuration
    always_ff @(posedge sys_clk or posedge reset)
        if (reset)
        begin
            insn      <= 16'h0;
            opnd      <= 16'h0;
            treg      <= 16'h0;
            blk0_prog <= 1'b0;
        end
        else if (wr)
        begin
            if (ix == `DSC_IX_INSN)
                insn <= m16(insn, wb_dat_w[15:0], wb_sel[1:0]);
            if (ix == `DSC_IX_OPND)
                opnd <= m16(opnd, wb_dat_w[15:0], wb_sel[1:0]);
            if (ix == `DSC_IX_TREG)
                treg <= m16(treg, wb_dat_w[15:0], wb_sel[1:0]);
            if (ix == `DSC_IX_MODE && wb_sel[0])
                blk0_prog <= wb_dat_w[`DSC_MD_BLK];
        end

    // Sign extend and shift mode bits deliberately lack a reset and power up unknown
    always_ff @(posedge sys_clk)
        if (wr && ix == `DSC_IX_MODE && wb_sel[0])
        begin
            sign_extend_enable <= wb_dat_w[`DSC_MD_SGN];
            pm  <= wb_dat_w[`DSC_MD_PSH];
        end

    // Status word zero: software write, select reload by opcodes
    always_ff @(posedge sys_clk or posedge reset)
        if (reset)
            st0 <= `DSC_ST0_RST;
        else if (wr && ix == `DSC_IX_ST0)
            st0 <= m16(st0, wb_dat_w[15:0], wb_sel[1:0]);
        else if (exec && mod_en && insn[`DSC_OP_LDS])
            st0[`DSC_ST_ASEL] <= insn[`DSC_OP_NSEL];

    // Aux registers
    always_ff @(posedge sys_clk or posedge reset)
        if (reset)
        begin
            for (int i = 0; i < 8; i++)
                ar[i] <= 16'h0;
        end
        else if (wr && ix[5:3] == `DSC_IX_AR)
            ar[ix[2:0]] <= m16(ar[ix[2:0]], wb_dat_w[15:0], wb_sel[1:0]);
        else if (exec && mod_en)
            ar[asel] <= ar_step(cur_ar, mod, ar[0]);

    // ************************************************
    // Arithmetic
    // ************************************************
    // Subtract-and-shift step, finished within the cycle
    assign sub_op   = {sign_extend_enable ? opnd[15] : 1'b0, opnd, 15'h0};
    assign sub_diff = {acc[31], acc} - {sub_op[31], sub_op};
    assign sub_res  = sub_diff[32] ? {acc[30:0], 1'b0} : {sub_diff[30:0], 1'b1};

    // Accumulator
    always_ff @(posedge sys_clk or posedge reset)
        if (reset)
            acc <= 32'h0;
        else if (wr && ix == `DSC_IX_ACC)
            acc <= {m16(acc[31:16], wb_dat_w[31:16], wb_sel[3:2]),
                    m16(acc[15:0], wb_dat_w[15:0], wb_sel[1:0])};
        else if (exec && cls == dsc_pkg::OPC_CSUB)
            acc <= sub_res;

    // Product; full 32-bit signed result holds the square of the most negative value
    always_ff @(posedge sys_clk or posedge reset)
        if (reset)
            prod <= 32'h0;
        else if (wr && ix == `DSC_IX_PROD)
            prod <= {m16(prod[31:16], wb_dat_w[31:16], wb_sel[3:2]),
                     m16(prod[15:0], wb_dat_w[15:0], wb_sel[1:0])};
        else if (exec && cls == dsc_pkg::OPC_MUL)
            prod <= $signed({{16{treg[15]}}, treg})                     // Widen before multiply
                    * $signed({{16{opnd[15]}}, opnd});
        else if (exec && cls == dsc_pkg::OPC_MULK)
            prod <= $signed({{16{treg[15]}}, treg})
                    * $signed({{20{insn[11]}}, insn[`DSC_OP_IMM]});

    // Program counter and return address
    always_ff @(posedge sys_clk or posedge reset)
        if (reset)
        begin
            pc     <= 16'h0;
            ret_pc <= 16'h0;
        end
        else if (exec)
            case (cls)
                dsc_pkg::OPC_BR:     pc <= opnd;
                dsc_pkg::OPC_BRACC:  pc <= acc[15:0];
                dsc_pkg::OPC_CALL:
                begin
                    ret_pc <= pc + 16'h1;
                    pc     <= opnd;
                end
                dsc_pkg::OPC_CALACC:
                begin
                    ret_pc <= pc + 16'h1;
                    pc     <= acc[15:0];
                end
                dsc_pkg::OPC_MISC:
                    if (arg == `DSC_MISC_BNZ && cur_ar != 16'h0)
                        pc <= opnd;
                    else
                        pc <= pc + 16'h1;
                default:             pc <= pc + 16'h1;
            endcase

    // ************************************************
    // Sequencer
    // ************************************************
    // One opcode per cycle; a pending repeat count reruns the next opcode
    always_ff @(posedge sys_clk or posedge reset)
        if (reset)
        begin
            state    <= dsc_pkg::DSC_IDLE;
            rpt_cnt  <= 8'h0;
            rpt_pend <= 8'h0;
        end
        else
            unique case (state)
                dsc_pkg::DSC_IDLE:
                    if (wr && ix == `DSC_IX_INSN)
                    begin
                        state    <= dsc_pkg::DSC_EXEC;
                        rpt_cnt  <= rpt_pend;
                        rpt_pend <= 8'h0;
                    end
                dsc_pkg::DSC_EXEC:
                begin
                    if (rpt_cnt == 8'h0)
                        state <= dsc_pkg::DSC_IDLE;
                    else
                        rpt_cnt <= rpt_cnt - 8'h1;
                    if (cls == dsc_pkg::OPC_MISC && arg == `DSC_MISC_REP)
                        rpt_pend <= opnd[7:0];
                    else if (cls == dsc_pkg::OPC_MISC && arg == `DSC_MISC_REPK)
                        rpt_pend <= insn[`DSC_OP_CNT];
                end
                default: state <= dsc_pkg::DSC_IDLE;
            endcase

    // Besides the mask bit, only repeats shut the window; multiplies are left open on purpose
    always_ff @(posedge sys_clk or posedge reset)
        if (reset)
            irq_window <= 1'b0;
        else
            irq_window <= !st0[`DSC_ST_MASK]
                          && !(exec && (rpt_cnt != 8'h0 || is_rep));

    // ************************************************
    // Memory and port strobes
    // ************************************************
    always_comb
    begin
        next_mem = '0;
        if (exec)
        begin
            next_mem.addr = ind ? cur_ar : dir_addr;
            case (cls)
                dsc_pkg::OPC_STS0, dsc_pkg::OPC_STS1:
                begin
                    next_mem.addr     = ind ? cur_ar : {9'h0, insn[`DSC_OP_OFF]};
                    next_mem.wdata    = (cls == dsc_pkg::OPC_STS0) ? st0_rd : st1_rd;
                    next_mem.wr       = 1'b1;
                    next_mem.data_sel = 1'b1;
                end
                dsc_pkg::OPC_STAR:
                begin
                    next_mem.wdata    = ar[arg[2:0]];
                    next_mem.wr       = 1'b1;
                    next_mem.data_sel = 1'b1;
                end
                dsc_pkg::OPC_STACC:
                begin
                    next_mem.wdata    = acc[15:0] << sh;
                    next_mem.wr       = 1'b1;
                    next_mem.data_sel = 1'b1;
                end
                dsc_pkg::OPC_MUL, dsc_pkg::OPC_CSUB:
                    next_mem.data_sel = 1'b1;
                dsc_pkg::OPC_TBLWR:
                begin
                    next_mem.addr     = acc[15:0];
                    next_mem.wdata    = opnd;
                    next_mem.wr       = 1'b1;
                    next_mem.prog_sel = 1'b1;
                end
                dsc_pkg::OPC_OUT, dsc_pkg::OPC_IN:
                begin
                    next_mem.addr     = {12'h0, arg};
                    next_mem.wdata    = opnd;
                    next_mem.wr       = (cls == dsc_pkg::OPC_OUT);
                    next_mem.io_sel   = 1'b1;
                end
                dsc_pkg::OPC_MISC:
                    next_mem.data_sel = (arg == `DSC_MISC_REP);
                default:
                    next_mem.addr = 16'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
        if (reset)
        begin
            mem        <= '0;
            mem_region <= dsc_pkg::RG_NONE;
        end
        else
        begin
            mem        <= next_mem;
            mem_region <= next_mem.data_sel ? region(next_mem.addr, blk0_prog)
                                            : dsc_pkg::RG_NONE;
        end

    // ************************************************
    // Assertions
    // ************************************************
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_run(dsc_pkg::dsc_opc_e c);
        exec && cls == c;
    endsequence
    sequence s_start;
        wr && ix == `DSC_IX_INSN && !busy;
    endsequence

    a_page_two_map: assert property (mem.data_sel && mem.addr[15:7] == 9'h0
        && mem.addr[6:5] == 2'b11 |-> mem_region == dsc_pkg::RG_BLK2)
        else $error("page zero block two not decoded");
    a_status_one_bit: assert property (wb_ack && $past(ix) == `DSC_IX_ST0
        && !$past(wb_we) |-> wb_dat_r[10])
        else $error("status bit ten not read as one");
    a_store_page_zero: assert property (s_run(dsc_pkg::OPC_STS0) and !ind
        |=> mem.wr && mem.addr == {9'h0, $past(insn[6:0])})
        else $error("status store left page zero");
    a_star_old_value: assert property (s_run(dsc_pkg::OPC_STAR) and ind
        && arg[2:0] == asel && mod != 3'h0 |=> mem.wdata == $past(cur_ar))
        else $error("aux store wrote modified value");
    a_branch_ar_step: assert property (s_run(dsc_pkg::OPC_BR) and mod == 3'h2
        |=> ar[$past(asel)] == $past(cur_ar) - 16'h1 && pc == $past(opnd))
        else $error("branch aux modify missing");
    a_stacc_shift4: assert property (s_run(dsc_pkg::OPC_STACC) and arg == 4'h4
        |=> mem.wdata == {$past(acc[11:0]), 4'h0})
        else $error("store shift by four wrong");
    a_square_corner: assert property (s_run(dsc_pkg::OPC_MUL) and treg == 16'h8000
        && opnd == 16'h8000 |=> prod == 32'h40000000)
        else $error("most negative square wrong");
    a_mul_irq_open: assert property (s_run(dsc_pkg::OPC_MUL) and rpt_cnt == 8'h0
        && !st0[`DSC_ST_MASK] |=> irq_window)
        else $error("multiply blocked interrupts");
    a_port_address: assert property (s_run(dsc_pkg::OPC_OUT)
        |=> mem.io_sel && !mem.prog_sel && mem.addr == {12'h0, $past(arg)})
        else $error("port write strobe or address wrong");
    a_table_strobe: assert property (s_run(dsc_pkg::OPC_TBLWR)
        |=> mem.prog_sel && !mem.io_sel && mem.wr)
        else $error("table write strobe wrong");
    a_repeat_span: assert property (s_start and rpt_pend == 8'h2
        |=> (state == dsc_pkg::DSC_EXEC)[*3] ##1 state == dsc_pkg::DSC_IDLE)
        else $error("repeat length wrong");
    a_ar_wraps: assert property (exec && mod_en && mod == 3'h1
        && cur_ar == 16'hffff |=> ar[$past(asel)] == 16'h0)
        else $error("aux register did not wrap");
    a_direct_join: assert property (s_run(dsc_pkg::OPC_CSUB) and !ind
        |=> mem.addr == {$past(st0[8:0]), $past(insn[6:0])})
        else $error("direct address not joined");
endmodule

// ### rtl/dsc_defs.svh
// Register indices, opcode fields and reset values of the core semantics block
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH
// Word indices; byte address is four times the index
`define DSC_IX_INSN  6'h00
`define DSC_IX_OPND  6'h01
`define DSC_IX_ST0   6'h02
`define DSC_IX_MODE  6'h03
`define DSC_IX_ACC   6'h04
`define DSC_IX_PROD  6'h05
`define DSC_IX_TREG  6'h06
`define DSC_IX_CORE  6'h07
`define DSC_IX_AR    3'h1
// Status word zero fields
`define DSC_ST_ASEL  15:13
`define DSC_ST_WRAP  12
`define DSC_ST_SAT   11
`define DSC_ST_ONE   10
`define DSC_ST_MASK  9
`define DSC_ST_PAGE  8:0
`define DSC_ST0_RST  16'h0200
// Mode register fields
`define DSC_MD_SGN   0
`define DSC_MD_PSH   2:1
`define DSC_MD_BLK   3
// Opcode fields
`define DSC_OP_CLS   15:12
`define DSC_OP_ARG   11:8
`define DSC_OP_IND   7
`define DSC_OP_MOD   6:4
`define DSC_OP_LDS   3
`define DSC_OP_NSEL  2:0
`define DSC_OP_OFF   6:0
`define DSC_OP_IMM   11:0
`define DSC_OP_CNT   7:0
// Sub codes of the misc class
`define DSC_MISC_REP  4'h0
`define DSC_MISC_REPK 4'h1
`define DSC_MISC_BNZ  4'h2
// Page map
`define DSC_MMR_TOP   7'h05
`define DSC_BLK2_SEL  2'b11
`define DSC_BLK0_PAGE 8'h02
`define DSC_BLK1_PAGE 8'h03
`endif

// ### rtl/dsc_pkg.sv
// Types shared by the core semantics block
package dsc_pkg;
    typedef enum logic [1:0] {DSC_IDLE = 2'b00, DSC_EXEC = 2'b01} dsc_state_e;
    typedef enum logic [2:0] {RG_NONE, RG_MMR, RG_BLK2, RG_BLK0, RG_BLK1, RG_EXT} dsc_region_e;
    typedef enum logic [3:0] {
        OPC_NOP, OPC_STS0, OPC_STS1, OPC_STAR, OPC_BR, OPC_CALL, OPC_BRACC, OPC_CALACC,
        OPC_STACC, OPC_MUL, OPC_MULK, OPC_TBLWR, OPC_OUT, OPC_IN, OPC_CSUB, OPC_MISC
    } dsc_opc_e;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        data_sel;
        logic        prog_sel;
        logic        io_sel;
    } dsc_mem_s;
endpackage

// ### sim/dsc_core_bench.sv
// Self-checking bench for the core semantics block, driven over Wishbone
module dsc_core_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 sys_clk    = 1'b0;
    logic                 reset      = 1'b1;
    logic                 cyc        = 1'b0;
    logic                 stb        = 1'b0;
    logic                 we         = 1'b0;
    logic [7:0]           adr        = 8'h00;
    logic [3:0]           sel        = 4'h0;
    logic [31:0]          dat_w      = 32'h0;
    logic [31:0]          dat_r;
    logic                 ack;
    logic                 irq_window;
    logic                 lw;
    logic [31:0]          q;
    dsc_pkg::dsc_mem_s    mem;
    dsc_pkg::dsc_mem_s    lm;
    dsc_pkg::dsc_region_e mem_region;
    dsc_pkg::dsc_region_e lr;
    int                   errors     = 0;
    int                   n_compared = 0;
    int                   cycles     = 0;
    logic [3:0]           sh[3]      = '{4'h0, 4'h1, 4'h4};
    logic [15:0]          sv[3]      = '{16'h1234, 16'h2468, 16'h2340};

    dsc_core i_dut (.sys_clk(sys_clk), .reset(reset), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
        .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dat_w), .wb_dat_r(dat_r), .wb_ack(ack),
        .mem(mem), .mem_region(mem_region), .irq_window(irq_window));

    // Free-running 20 MHz clock
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    // Keep the last memory pulse and the interrupt window of the same cycle beside it
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (mem != '0)
        begin
            lm <= mem;
            lr <= mem_region;
            lw <= irq_window;
        end
        if (cycles == 4000)
        begin
            errors++;
            $display("ERROR %0t timeout", $time);
            test_done();
        end
    end

    // ************************************************************
    // Bus tasks and comparison
    // ************************************************************
    // Request held until ack is sampled; stalls during execution are waited out
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat_w <= d;
        @(posedge sys_clk);
        while (ack !== 1'b1) @(posedge sys_clk);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // Launch one opcode and let its memory pulse be captured
    task automatic ex(input logic [15:0] insn);
        bus(1'b1, 8'h00, {16'h0, insn});
        @(posedge sys_clk);
    endtask

    task automatic test_done();
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(8'h08, 32'h0600);
        bus(1'b1, 8'h0c, 32'h1);
        rd(8'h0c, 32'h1);
        bus(1'b1, 8'h08, 32'hbbff);
        rd(8'h08, 32'hbfff);
        bus(1'b1, 8'h08, 32'h4004);
        ex(16'h1060);
        chk(lm.addr, 16'h0060);
        chk(lr, dsc_pkg::RG_BLK2);
        ex(16'h1010);
        chk(lr, dsc_pkg::RG_NONE);
        bus(1'b1, 8'h10, 32'h1234);
        for (int i = 0; i < 3; i++)
        begin
            ex({4'h8, sh[i], 8'h05});
            chk({lm.addr, lm.wdata}, {16'h0205, sv[i]});
        end
        chk(lr, dsc_pkg::RG_BLK0);
        // Selected register stored while post-incremented across the wrap
        bus(1'b1, 8'h28, 32'hffff);
        ex(16'h3290);
        chk({lm.addr, lm.wdata}, 32'hffffffff);
        rd(8'h28, 32'h0);
        bus(1'b1, 8'h04, 32'h55);
        ex(16'h40a0);
        rd(8'h28, 32'hffff);
        ex(16'h60a0);
        rd(8'h28, 32'hffff);
        rd(8'h1c, 32'h00000034);
        ex(16'hf2a0);
        rd(8'h28, 32'hfffe);
        rd(8'h1c, 32'h00000055);
        bus(1'b1, 8'h18, 32'h8000);
        bus(1'b1, 8'h04, 32'h8000);
        ex(16'h9000);
        rd(8'h14, 32'h40000000);
        chk(lw, 1'b1);
        ex(16'hc500);
        chk({13'h0, lm.prog_sel, lm.io_sel, lm.wr, lm.addr}, 32'h00030005);
        ex(16'hcf00);
        chk({13'h0, lm.prog_sel, lm.io_sel, lm.wr, lm.addr}, 32'h0003000f);
        bus(1'b1, 8'h10, 32'h3);
        ex(16'hb000);
        chk({13'h0, lm.prog_sel, lm.io_sel, lm.wr, lm.addr}, 32'h00050003);
        // Three repeated subtracts, then a readback and a store of the result
        bus(1'b1, 8'h10, 32'h10000);
        bus(1'b1, 8'h04, 32'h1);
        ex(16'hf102);
        chk(lw, 1'b0);
        ex(16'he000);
        rd(8'h10, 32'h10007);
        ex(16'h8005);
        chk(lm.wdata, 16'h0007);
        test_done();
    end
endmodule
